//--- bench/core_model.sv
// stand-in for the core execution unit and memory side of the stack block
// assumes the block's clock; every request changes just after a rising edge
module core_model (
   input wire logic clk, // core clock
   output stack_addr_pkg::stack_op_t stack_op, // stack operation
   output stack_addr_pkg::push_kind_t push_kind, // push kind
   output logic [15:0] push_data_word, // pushed data
   output logic [22:0] prog_counter, // program counter
   output logic [7:0] status_low_byte, // status low byte
   output logic [15:0] ref_ea, // pointer-based address
   output logic [15:0] data_ea, // data address
   output logic table_read_op, // table read
   output logic table_write_op, // table write
   output logic cfg_implemented, // config place exists
   output logic window_read // window read
);
   timeunit 1ns;
   timeprecision 100ps;
   import stack_addr_pkg::*;
   initial begin
      stack_op = op_none;
      push_kind = push_data;
      push_data_word = 16'h0000;
      prog_counter = 23'h00_0000;
      status_low_byte = 8'h00;
      ref_ea = 16'h0000;
      {data_ea, table_read_op, table_write_op, cfg_implemented, window_read} = '0;
   end
   // ****************************************
   // requests
   // ****************************************
   // pc low word follows the data and status is its inverted low byte; the pc upper part stays 7Ah on every push
   task automatic stk(input stack_op_t op, input push_kind_t k, input logic [15:0] d);
      @(posedge clk);
      stack_op <= op;
      push_kind <= k;
      push_data_word <= d;
      ref_ea <= d;
      prog_counter <= {7'h7A, d};
      status_low_byte <= ~d[7:0];
      #1;
   endtask
   // idle data lines scramble, so nothing leans on stale values
   task automatic idle();
      @(posedge clk);
      stack_op <= op_none;
      push_data_word <= ~push_data_word;
      ref_ea <= ~ref_ea;
      #1;
   endtask
   task automatic mem(input logic [15:0] ea, input logic tr, tw, impl, wrd);
      @(posedge clk);
      data_ea <= ea;
      table_read_op <= tr;
      table_write_op <= tw;
      cfg_implemented <= impl;
      window_read <= wrd;
      #1;
   endtask
endmodule // core_model

//--- bench/stack_limit_and_program_addr_gen_tb.sv
// self-checking bench for the stack limit unit and program address former
// assumes the core model drives the core side and this module the register bus
module stack_limit_and_program_addr_gen_tb;
   timeunit 1ns;
   timeprecision 100ps;
   import stack_addr_pkg::*;
   logic clk = 1'b0;
   logic reset = 1'b1;
   axi_req_t req = '0;
   axi_rsp_t rsp;
   stack_op_t stack_op;
   push_kind_t push_kind;
   logic [15:0] push_data_word, ref_ea, data_ea, stack_mem_addr, w0, w1;
   logic [22:0] prog_counter, window_addr;
   logic [7:0] status_low_byte;
   logic [23:0] table_addr;
   logic tr_op, tw_op, impl, win_rd, we, trap, to_cfg, tbl_ok, win_act, stall;
   logic [15:0] rea [4] = '{16'h07FE, 16'h0800, 16'h0DF4, 16'h0DF6};
   logic rtr [4] = '{1'b1, 1'b0, 1'b0, 1'b1};
   int n_mismatch = 0;
   int n_checks = 0;
   always #5 clk = ~clk;
   core_model core (.clk(clk), .stack_op(stack_op), .push_kind(push_kind),
      .push_data_word(push_data_word), .prog_counter(prog_counter),
      .status_low_byte(status_low_byte), .ref_ea(ref_ea), .data_ea(data_ea),
      .table_read_op(tr_op), .table_write_op(tw_op), .cfg_implemented(impl),
      .window_read(win_rd));
   stack_limit_unit dut (.clk(clk), .reset(reset), .axi_req(req), .axi_rsp(rsp),
      .stack_op(stack_op), .push_kind(push_kind), .push_data_word(push_data_word),
      .prog_counter(prog_counter), .status_low_byte(status_low_byte), .ref_ea(ref_ea),
      .stack_mem_addr(stack_mem_addr), .stack_mem_we(we), .stack_wr_word0(w0),
      .stack_wr_word1(w1), .stack_error_trap(trap), .data_ea(data_ea),
      .table_read_op(tr_op), .table_write_op(tw_op), .cfg_implemented(impl),
      .window_read(win_rd), .table_addr(table_addr), .table_to_cfg(to_cfg),
      .table_allowed(tbl_ok), .window_addr(window_addr), .window_active(win_act),
      .extra_cycle_stall(stall));
   // ****************************************
   // checking and bus tasks
   // ****************************************
   task automatic chk(input string nm, input logic [31:0] got, exp);
      n_checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("[ERR] %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task test_done;
      $display("checks %0d mismatches %0d", n_checks, n_mismatch);
      if (n_mismatch == 0 && n_checks > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   task hang;
      n_mismatch++;
      test_done;
   endtask
   task automatic so(input logic [15:0] a, input logic w, t);
      chk("mem_addr", {16'h0000, stack_mem_addr}, {16'h0000, a});
      chk("mem_we", {31'h0, we}, {31'h0, w});
      chk("trap", {31'h0, trap}, {31'h0, t});
   endtask
   // address and data go out together; each is dropped once taken
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
      int i;
      @(posedge clk);
      req.awvalid <= 1'b1;
      req.awaddr <= a;
      req.wvalid <= 1'b1;
      req.wdata <= d;
      req.wstrb <= 4'hF;
      req.bready <= 1'b1;
      for (i = 0; i < 20; i++) begin
         @(posedge clk);
         if (req.awvalid && rsp.awready) req.awvalid <= 1'b0;
         if (req.wvalid && rsp.wready) req.wvalid <= 1'b0;
         if (rsp.bvalid) break;
      end
      if (i == 20) hang();
      req.bready <= 1'b0;
      chk("bresp", {30'h0, rsp.bresp}, {30'h0, er});
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
      int i;
      @(posedge clk);
      req.arvalid <= 1'b1;
      req.araddr <= a;
      req.rready <= 1'b1;
      for (i = 0; i < 20; i++) begin
         @(posedge clk);
         if (req.arvalid && rsp.arready) req.arvalid <= 1'b0;
         if (rsp.rvalid) break;
      end
      if (i == 20) hang();
      req.rready <= 1'b0;
      chk("rdata", rsp.rdata, d);
      chk("rresp", {30'h0, rsp.rresp}, {30'h0, er});
   endtask
   // ****************************************
   // main sequence
   // ****************************************
   initial begin
      repeat (16) @(posedge clk);
      reset <= 1'b0;
      rd(off_stack_ptr, 32'h0000_0800, axi_okay);
      rd(off_window_page, 32'h0000_0000, axi_okay);
      wr(off_stack_bound, 32'h0000_0DF5, axi_okay);
      rd(off_stack_bound, 32'h0000_0DF4, axi_okay);
      core.idle();
      core.stk(op_push, push_data, 16'h1234);
      so(16'h0800, 1'b1, 1'b0);
      chk("word0", {16'h0, w0}, 32'h0000_1234);
      core.idle();
      rd(off_stack_ptr, 32'h0000_0802, axi_okay);
      core.stk(op_pop, push_data, 16'h0000);
      so(16'h0800, 1'b0, 1'b0);
      core.stk(op_pop, push_data, 16'h0000);
      so(16'h07FE, 1'b0, 1'b1);
      core.idle();
      rd(off_status, 32'h0000_0001, axi_okay);
      wr(off_status, 32'h0000_0001, axi_okay);
      rd(off_status, 32'h0000_0000, axi_okay);
      wr(off_stack_ptr, 32'h0000_0DF4, axi_okay);
      core.stk(op_push, push_data, 16'hAAAA);
      so(16'h0DF4, 1'b1, 1'b0);
      core.stk(op_push, push_data, 16'h5555);
      so(16'h0DF6, 1'b1, 1'b1);
      for (int k = 0; k < 4; k++) begin
         core.stk(op_ref, push_data, rea[k]);
         so(rea[k], 1'b0, rtr[k]);
      end
      core.idle();
      wr(off_stack_ptr, 32'h0000_0900, axi_okay);
      core.stk(op_push, push_call, 16'hBCDF);
      so(16'h0900, 1'b1, 1'b0);
      chk("call_w0", {16'h0, w0}, 32'h0000_BCDE);
      chk("call_w1", {16'h0, w1}, 32'h0000_007A);
      core.stk(op_push, push_exc, 16'h1235);
      so(16'h0904, 1'b1, 1'b0);
      chk("exc_w1", {16'h0, w1}, 32'h0000_CA7A);
      core.idle();
      rd(off_stack_ptr, 32'h0000_0908, axi_okay);
      wr(off_table_page, 32'h0000_0085, axi_okay);
      core.mem(16'h1235, 1'b1, 1'b0, 1'b1, 1'b0);
      chk("tbl_addr", {8'h0, table_addr}, 32'h0085_1235);
      chk("to_cfg", {31'h0, to_cfg}, 32'h1);
      chk("tbl_ok", {31'h0, tbl_ok}, 32'h1);
      core.mem(16'h1235, 1'b1, 1'b0, 1'b0, 1'b0);
      chk("tbl_ok", {31'h0, tbl_ok}, 32'h0);
      core.mem(16'h1235, 1'b0, 1'b1, 1'b1, 1'b0);
      chk("tbl_ok", {31'h0, tbl_ok}, 32'h0);
      wr(off_table_page, 32'h0000_0005, axi_okay);
      chk("to_cfg", {31'h0, to_cfg}, 32'h0);
      chk("tbl_ok", {31'h0, tbl_ok}, 32'h1);
      wr(off_window_page, 32'h0000_00FF, axi_okay);
      core.mem(16'h8123, 1'b0, 1'b0, 1'b0, 1'b1);
      chk("win_addr", {9'h0, window_addr}, 32'h007F_8123);
      chk("win_act", {31'h0, win_act}, 32'h1);
      chk("stall", {31'h0, stall}, 32'h1);
      core.mem(16'h8123, 1'b0, 1'b0, 1'b0, 1'b1);
      chk("stall", {31'h0, stall}, 32'h0);
      core.mem(16'h0123, 1'b0, 1'b0, 1'b0, 1'b1);
      chk("win_act", {31'h0, win_act}, 32'h0);
      wr(off_window_page, 32'h0000_0000, axi_okay);
      core.mem(16'hFFFF, 1'b0, 1'b0, 1'b0, 1'b1);
      chk("win_addr", {9'h0, window_addr}, 32'h0000_7FFF);
      wr(off_window_page, 32'h0000_0012, axi_okay);
      chk("win_act", {31'h0, win_act}, 32'h0);
      core.mem(16'h0000, 1'b0, 1'b0, 1'b0, 1'b0);
      rd(8'h14, 32'h0000_0000, axi_slverr);
      wr(8'h14, 32'h0000_0001, axi_slverr);
      test_done;
   end
endmodule // stack_limit_and_program_addr_gen_tb

//--- logic/program_addr_gen.sv
// program address former for table and window accesses
// assumes page registers and effective address are on the core clock
module program_addr_gen (
   input wire logic [7:0] table_page_reg, // table page
   input wire logic [7:0] window_page_reg, // window page
   input wire logic [15:0] data_ea, // data effective address
   input wire logic table_read_op, // table read request
   input wire logic table_write_op, // table write request
   input wire logic cfg_implemented, // addressed configuration place exists
   output logic [23:0] table_addr, // table program address
   output logic table_to_cfg, // table access targets configuration
   output logic table_allowed, // table access may proceed
   output logic [22:0] window_addr, // window program address
   output logic window_hit, // data address falls in window
   output logic window_page_ok // window page has a meaningful value
);
   import stack_addr_pkg::*;
   // no alignment check on purpose: byte table accesses use bit 0
   assign table_addr = {table_page_reg, data_ea};
   assign table_to_cfg = table_page_reg[table_cfg_bit];
   assign table_allowed = table_to_cfg ?
      (table_read_op & cfg_implemented & ~table_write_op) :
      (table_read_op | table_write_op);
   assign window_hit = data_ea[ea_window_bit];
   // 23 bits only, so bit 23 is implicitly zero: user memory only
   assign window_addr = {window_page_reg, data_ea[14:0]};
   assign window_page_ok = (window_page_reg == window_pg_prog) |
      (window_page_reg == window_pg_eeprom);
endmodule // program_addr_gen

//--- logic/stack_addr_pkg.sv
// package for the stack limit checker and program address generator
// assumes one core clock, synchronous active-high reset, 32-bit axi4-lite register bus
// What this block does
// - stack pointer holds the first free word and grows upward.
// - pop decrements before reading; push writes then increments.
// - call push zero-extends the program counter's upper part.
// - exception push places status low byte beside upper program counter.
// - upper bound has no reset value; its bit zero is always zero.
// - every stack-pointer based address is compared with the upper bound.
// - push at pointer equal to bound is fine; the next one traps.
// - stack-pointer based address below 0800h raises an underflow stack error trap.
// - table address is table page above the 16-bit effective address.
// - table page top bit picks user or configuration memory.
// - window address is window page then effective address bits 14..0.
// - window accesses reach user memory only; top address bit zero.
// - window ignores address bit 15; page bit 0 supplies program bit 15.
// - window page meaningful only at 00 (program) or FF (eeprom).
// - window page is 16K words, read-only, low word only.
// - table accesses need no alignment; reads allowed in configuration space.
// - configuration table access only reads implemented places; writes refused.
// - a window read adds one extra instruction cycle.
package stack_addr_pkg;
   // ****************************************
   // register offsets (byte addresses)
   // ****************************************
   localparam logic [7:0] off_stack_ptr = 8'h00;
   localparam logic [7:0] off_stack_bound = 8'h04;
   localparam logic [7:0] off_table_page = 8'h08;
   localparam logic [7:0] off_window_page = 8'h0C;
   localparam logic [7:0] off_status = 8'h10;
   // ****************************************
   // fields and values
   // ****************************************
   localparam logic [15:0] stack_floor = 16'h0800;
   localparam logic [15:0] stack_ptr_rst = 16'h0800;
   localparam logic [7:0] page_rst = 8'h00;
   localparam logic [7:0] window_pg_prog = 8'h00;
   localparam logic [7:0] window_pg_eeprom = 8'hFF;
   localparam int table_cfg_bit = 7;
   localparam int ea_window_bit = 15;
   localparam logic [1:0] axi_okay = 2'b00;
   localparam logic [1:0] axi_slverr = 2'b10;

   typedef enum logic [1:0] {
      op_none = 2'b00,
      op_push = 2'b01,
      op_pop = 2'b11,
      op_ref = 2'b10
   } stack_op_t;

   typedef enum logic [1:0] {
      push_data = 2'b00,
      push_call = 2'b01,
      push_exc = 2'b11
   } push_kind_t;

   typedef struct packed {
      logic awvalid;
      logic [7:0] awaddr;
      logic wvalid;
      logic [31:0] wdata;
      logic [3:0] wstrb;
      logic bready;
      logic arvalid;
      logic [7:0] araddr;
      logic rready;
   } axi_req_t;

   typedef struct packed {
      logic awready;
      logic wready;
      logic bvalid;
      logic [1:0] bresp;
      logic arready;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
   } axi_rsp_t;
endpackage

//--- logic/stack_limit_unit.sv
// stack pointer tracking, bound check and address generation with axi4-lite registers
// assumes execution unit issues at most one stack operation per cycle
module stack_limit_unit (
   input wire logic clk, // core clock
   input wire logic reset, // synchronous active-high reset
   input stack_addr_pkg::axi_req_t axi_req, // axi4-lite request
   output stack_addr_pkg::axi_rsp_t axi_rsp, // axi4-lite response
   input wire stack_addr_pkg::stack_op_t stack_op, // stack operation this cycle
   input wire stack_addr_pkg::push_kind_t push_kind, // kind of push
   input wire logic [15:0] push_data_word, // data to push
   input wire logic [22:0] prog_counter, // program counter
   input wire logic [7:0] status_low_byte, // status low byte
   input wire logic [15:0] ref_ea, // pointer-based address for op_ref
   output logic [15:0] stack_mem_addr, // stack memory address this cycle
   output logic stack_mem_we, // stack memory write strobe
   output logic [15:0] stack_wr_word0, // first pushed word (pc low on calls)
   output logic [15:0] stack_wr_word1, // second pushed word (pc upper part)
   output logic stack_error_trap, // stack error trap request
   input wire logic [15:0] data_ea, // data effective address
   input wire logic table_read_op, // table read
   input wire logic table_write_op, // table write
   input wire logic cfg_implemented, // config place implemented
   input wire logic window_read, // data read via window
   output logic [23:0] table_addr, // table address
   output logic table_to_cfg, // config target
   output logic table_allowed, // table permitted
   output logic [22:0] window_addr, // window address
   output logic window_active, // window read in progress
   output logic extra_cycle_stall // stretch instruction by one cycle
);
   import stack_addr_pkg::*;

   // ****************************************
   // state
   // ****************************************
   typedef struct packed {
      logic [15:0] stack_ptr;
      logic [15:0] bound;
      logic [7:0] tpage;
      logic [7:0] wpage;
      logic aw_held;
      logic [7:0] aw_addr;
      logic w_held;
      logic [31:0] w_data;
      logic [3:0] w_strb;
      logic bvalid;
      logic [1:0] bresp;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
      logic trap_seen;
      logic stall;
   } state_t;

   state_t st_ff, nxt_st;
   logic [15:0] ea;
   logic ea_used;
   logic over, under;
   logic win_hit, page_ok;
   logic do_write;
   logic [7:0] waddr;
   logic [31:0] wd;

   // ****************************************
   // address generation
   // ****************************************
   always_comb begin
      ea = st_ff.stack_ptr;
      ea_used = 1'b1;
      unique case (stack_op)
         op_push: ea = st_ff.stack_ptr;
         op_pop: ea = st_ff.stack_ptr - 16'h0002;
         op_ref: ea = ref_ea;
         op_none: ea_used = 1'b0;
      endcase
   end

   assign over = ea_used & (ea > st_ff.bound);
   assign under = ea_used & (ea < stack_floor);
   assign stack_error_trap = over | under;
   assign stack_mem_addr = ea;
   assign stack_mem_we = (stack_op == op_push);
   always_comb begin
      stack_wr_word0 = push_data_word;
      stack_wr_word1 = 16'h0000;
      unique case (push_kind)
         push_data: stack_wr_word0 = push_data_word;
         push_call: begin
            stack_wr_word0 = {prog_counter[15:1], 1'b0};
            stack_wr_word1 = {9'h000, prog_counter[22:16]};
         end
         push_exc: begin
            stack_wr_word0 = {prog_counter[15:1], 1'b0};
            stack_wr_word1 = {status_low_byte, 1'b0, prog_counter[22:16]};
         end
         default: stack_wr_word1 = 16'h0000;
      endcase
   end

   program_addr_gen u_pag (
      .table_page_reg(st_ff.tpage),
      .window_page_reg(st_ff.wpage),
      .data_ea(data_ea),
      .table_read_op(table_read_op),
      .table_write_op(table_write_op),
      .cfg_implemented(cfg_implemented),
      .table_addr(table_addr),
      .table_to_cfg(table_to_cfg),
      .table_allowed(table_allowed),
      .window_addr(window_addr),
      .window_hit(win_hit),
      .window_page_ok(page_ok)
   );
   // table access suspends the window
   assign window_active = window_read & win_hit & page_ok & ~table_read_op & ~table_write_op;
   // two fetches: stall first cycle only
   assign extra_cycle_stall = window_active & ~st_ff.stall;

   // ****************************************
   // register bus and next state
   // ****************************************
   always_comb begin
      nxt_st = st_ff;
      do_write = 1'b0;
      nxt_st.stall = extra_cycle_stall;
      nxt_st.trap_seen = st_ff.trap_seen | stack_error_trap;
      // pointer update; call/exception pushes occupy two words
      if (stack_op == op_push) begin
         nxt_st.stack_ptr = st_ff.stack_ptr +
            ((push_kind == push_data) ? 16'h0002 : 16'h0004);
      end else if (stack_op == op_pop) begin
         nxt_st.stack_ptr = st_ff.stack_ptr - 16'h0002;
      end
      if (axi_req.awvalid & ~st_ff.aw_held) begin
         nxt_st.aw_held = 1'b1;
         nxt_st.aw_addr = axi_req.awaddr;
      end
      if (axi_req.wvalid & ~st_ff.w_held) begin
         nxt_st.w_held = 1'b1;
         nxt_st.w_data = axi_req.wdata;
         nxt_st.w_strb = axi_req.wstrb;
      end
      // taken inside the process so the decode does not feed back through a net
      waddr = nxt_st.aw_addr;
      wd = nxt_st.w_data;
      if (nxt_st.aw_held & nxt_st.w_held & ~st_ff.bvalid) begin
         do_write = 1'b1;
         nxt_st.aw_held = 1'b0;
         nxt_st.w_held = 1'b0;
         nxt_st.bvalid = 1'b1;
         nxt_st.bresp = axi_okay;
         unique case (waddr)
            off_stack_ptr: if (nxt_st.w_strb[0] & nxt_st.w_strb[1]) begin
               nxt_st.stack_ptr = {wd[15:1], 1'b0};
            end
            off_stack_bound: if (nxt_st.w_strb[0] & nxt_st.w_strb[1]) begin
               nxt_st.bound = {wd[15:1], 1'b0};
            end
            off_table_page: if (nxt_st.w_strb[0]) begin
               nxt_st.tpage = wd[7:0];
            end
            off_window_page: if (nxt_st.w_strb[0]) begin
               nxt_st.wpage = wd[7:0];
            end
            off_status: begin
               // write one to clear; a new trap this cycle wins
               if (nxt_st.w_strb[0] & wd[0] & ~stack_error_trap) begin
                  nxt_st.trap_seen = 1'b0;
               end
            end
            default: nxt_st.bresp = axi_slverr;
         endcase
      end
      if (st_ff.bvalid & axi_req.bready) begin
         nxt_st.bvalid = 1'b0;
      end
      if (axi_req.arvalid & ~st_ff.rvalid) begin
         nxt_st.rvalid = 1'b1;
         nxt_st.rresp = axi_okay;
         unique case (axi_req.araddr)
            off_stack_ptr: nxt_st.rdata = {16'h0000, st_ff.stack_ptr};
            off_stack_bound: nxt_st.rdata = {16'h0000, st_ff.bound[15:1], 1'b0};
            off_table_page: nxt_st.rdata = {24'h00_0000, st_ff.tpage};
            off_window_page: nxt_st.rdata = {24'h00_0000, st_ff.wpage};
            off_status: nxt_st.rdata = {31'h0000_0000, st_ff.trap_seen};
            default: begin
               nxt_st.rdata = 32'h0000_0000;
               nxt_st.rresp = axi_slverr;
            end
         endcase
      end else if (st_ff.rvalid & axi_req.rready) begin
         nxt_st.rvalid = 1'b0;
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         st_ff.stack_ptr <= stack_ptr_rst;
         st_ff.tpage <= page_rst;
         st_ff.wpage <= page_rst;
         st_ff.aw_held <= 1'b0;
         st_ff.aw_addr <= 8'h00;
         st_ff.w_held <= 1'b0;
         st_ff.w_data <= 32'h0000_0000;
         st_ff.w_strb <= 4'h0;
         st_ff.bvalid <= 1'b0;
         st_ff.bresp <= axi_okay;
         st_ff.rvalid <= 1'b0;
         st_ff.rdata <= 32'h0000_0000;
         st_ff.rresp <= axi_okay;
         st_ff.trap_seen <= 1'b0;
         st_ff.stall <= 1'b0;
         st_ff.bound <= nxt_st.bound;
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign axi_rsp.awready = ~st_ff.aw_held;
   assign axi_rsp.wready = ~st_ff.w_held;
   assign axi_rsp.bvalid = st_ff.bvalid;
   assign axi_rsp.bresp = st_ff.bresp;
   assign axi_rsp.arready = ~st_ff.rvalid;
   assign axi_rsp.rvalid = st_ff.rvalid;
   assign axi_rsp.rdata = st_ff.rdata;
   assign axi_rsp.rresp = st_ff.rresp;

   // ****************************************
   // checks
   // ****************************************
   sequence s_push_at_bound;
      stack_op == op_push && st_ff.stack_ptr == st_ff.bound && push_kind == push_data;
   endsequence
   sequence s_next_push;
      stack_op == op_push;
   endsequence
   // a bus write in the same cycle would move the pointer elsewhere
   sequence s_quiet_push_at_bound;
      s_push_at_bound ##0 !do_write;
   endsequence

   a_push_at_bound: assert property (@(posedge clk) disable iff (reset)
      s_push_at_bound |-> !stack_error_trap)
      else $error("push at bound trapped");
   a_push_past_bound: assert property (@(posedge clk) disable iff (reset)
      s_quiet_push_at_bound ##1 s_next_push |-> stack_error_trap)
      else $error("push past bound did not trap");
   a_under_trap: assert property (@(posedge clk) disable iff (reset)
      (stack_op != op_none && stack_mem_addr < stack_floor) |-> stack_error_trap)
      else $error("underflow not trapped");
   a_pop_predec: assert property (@(posedge clk) disable iff (reset)
      stack_op == op_pop |-> stack_mem_addr == st_ff.stack_ptr - 16'h0002)
      else $error("pop address wrong");
   a_push_postinc: assert property (@(posedge clk) disable iff (reset)
      (stack_op == op_push && push_kind == push_data && !do_write)
      |=> st_ff.stack_ptr == $past(st_ff.stack_ptr) + 16'h0002)
      else $error("push increment wrong");
   a_call_zero: assert property (@(posedge clk) disable iff (reset)
      push_kind == push_call |-> stack_wr_word1[15:7] == 9'h000)
      else $error("call upper bits not clear");
   a_exc_status: assert property (@(posedge clk) disable iff (reset)
      push_kind == push_exc |-> stack_wr_word1[15:8] == status_low_byte)
      else $error("status byte missing");
   a_bound_even: assert property (@(posedge clk) disable iff (reset)
      axi_rsp.rvalid && $past(axi_req.araddr) == 8'h04 && $rose(axi_rsp.rvalid)
      |-> axi_rsp.rdata[0] == 1'b0)
      else $error("bound bit zero set");
   a_table_cat: assert property (@(posedge clk) disable iff (reset)
      table_addr[15:0] == data_ea && table_addr[23:16] == st_ff.tpage)
      else $error("table address wrong");
   a_cfg_write: assert property (@(posedge clk) disable iff (reset)
      (table_write_op && st_ff.tpage[7]) |-> !table_allowed)
      else $error("config write allowed");
   a_window_bit15: assert property (@(posedge clk) disable iff (reset)
      window_addr[15] == st_ff.wpage[0])
      else $error("window bit 15 wrong");
   a_window_stall: assert property (@(posedge clk) disable iff (reset)
      (window_active && !st_ff.stall) |-> extra_cycle_stall ##1 !extra_cycle_stall)
      else $error("window extra cycle wrong");
endmodule // stack_limit_unit
